// >>> logic/jtp_cfg.svh
/*
 jtp_cfg.svh: offsets, field positions, reset values and counts of the
 scan-path block. Assumes nothing; definitions only.
*/
`ifndef JTP_CFG_SVH
`define JTP_CFG_SVH

`define JTP_BSR_LEN 70
`define JTP_IR_LEN 4
`define JTP_IR_CAPTURE 4'h1
`define JTP_IR_EXTEST 4'h0
`define JTP_IR_SAMPLE 4'h1
`define JTP_IR_BYPASS 4'hf
`define JTP_IR_RESET 4'h2
`define JTP_CELL_CTRL1 17
`define JTP_CELL_CTRL2 18
`define JTP_CELL_LOCK 27
`define JTP_CELL_AD 54
`define JTP_PIN_TCK 0
`define JTP_PIN_TMS 1
`define JTP_PIN_TDI 2
`define JTP_PIN_TRST 3
`define JTP_PIN_COUNT 4
`define JTP_SYNC_DEPTH 3
`define JTP_TLR_TMS_EDGES 5
`define JTP_BUF_DEPTH 2

`endif

// >>> logic/jtp_pkg.sv
/*
 jtp_pkg: types of the scan-path block.
 Assumes jtp_cfg.svh is on the include path.
*/
`default_nettype none
`include "jtp_cfg.svh"

package jtp_pkg;

    typedef enum logic [3:0] {
        st_tlr = 4'h0, st_rti = 4'h1, st_sel_dr = 4'h2, st_cap_dr = 4'h3,
        st_sh_dr = 4'h4, st_ex1_dr = 4'h5, st_pa_dr = 4'h6, st_ex2_dr = 4'h7,
        st_upd_dr = 4'h8, st_sel_ir = 4'h9, st_cap_ir = 4'ha, st_sh_ir = 4'hb,
        st_ex1_ir = 4'hc, st_pa_ir = 4'hd, st_ex2_ir = 4'he, st_upd_ir = 4'hf
    } jtp_tap_state_type;

    typedef logic [`JTP_BSR_LEN-1:0] jtp_bsr_type;
    typedef logic [`JTP_IR_LEN-1:0] jtp_ir_type;

    typedef struct packed {
        logic [`JTP_PIN_COUNT-1:0][`JTP_SYNC_DEPTH-1:0] sync;
        logic [`JTP_PIN_COUNT-1:0] lvl;
        logic pend_rise;
        logic pend_fall;
        logic pend_tms;
        logic pend_tdi;
        jtp_tap_state_type tap;
        jtp_ir_type ir_shift;
        jtp_ir_type ir_cur;
        jtp_bsr_type bsr_shift;
        jtp_bsr_type bsr_latch;
        logic bypass;
        logic tdo;
        logic tdo_oe_n;
    } jtp_core_state_type;

endpackage : jtp_pkg
`default_nettype wire

// >>> logic/jtp_buf2.sv
/*
 jtp_buf2: small valid/ready buffer, width and depth as parameters.
 Assumes one clock, synchronous active-low reset and a clock enable.
*/
`timescale 1ns/1ns
`default_nettype none
`include "jtp_cfg.svh"

module jtp_buf2
    import jtp_pkg::*;
#(
    parameter int WIDTH = `JTP_BSR_LEN,
    parameter int DEPTH = `JTP_BUF_DEPTH
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } jtp_buf_state_type;

    jtp_buf_state_type st;
    jtp_buf_state_type next_st;
    logic push;
    logic pop;

    // handshakes close while frozen so no word slips past the enable
    assign in_ready_out = ce_in && (st.cnt != (AW+1)'(DEPTH));
    assign out_valid_out = ce_in && (st.cnt != '0);
    assign out_data_out = st.mem[st.rd];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = in_data_in;
            next_st.wr = (st.wr == AW'(DEPTH-1)) ? '0 : st.wr + AW'(1);
        end
        if (pop) begin
            next_st.rd = (st.rd == AW'(DEPTH-1)) ? '0 : st.rd + AW'(1);
        end
        if (push && !pop) begin
            next_st.cnt = st.cnt + (AW+1)'(1);
        end else if (pop && !push) begin
            next_st.cnt = st.cnt - (AW+1)'(1);
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            st <= '0;
        end else if (ce_in) begin
            st <= next_st;
        end
    end

endmodule : jtp_buf2
`default_nettype wire

// >>> logic/jtp_scan_path.sv
/*
 jtp_scan_path: test access port controller with instruction and
 boundary-scan paths, sampled from pins by the core clock.
 Assumes tck, tms, tdi and trst_n come from pins; pins_in is already
 synchronous to core_clk_in; tck is slow beside the core clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "jtp_cfg.svh"

module jtp_scan_path
    import jtp_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    input wire logic trst_n_in,
    input wire jtp_bsr_type pins_in,
    output logic tdo_out,
    output logic tdo_oe_n_out,
    output jtp_bsr_type bsr_latch_out,
    output logic ad_oe_n_out,
    output logic lock_oe_n_out,
    output jtp_tap_state_type tap_state_out,
    output jtp_ir_type ir_out,
    input wire logic upd_ready_in,
    output logic upd_valid_out,
    output jtp_bsr_type upd_word_out
);

    localparam jtp_core_state_type RESET_ST = '{
        tap: st_tlr,
        ir_cur: `JTP_IR_RESET,
        tdo_oe_n: 1'b1,
        default: '0
    };

    function automatic jtp_tap_state_type tap_next(
        input jtp_tap_state_type s,
        input logic tms
    );
        jtp_tap_state_type n;
        n = s;
        unique case (s)
            st_tlr: n = tms ? st_tlr : st_rti;
            st_rti: n = tms ? st_sel_dr : st_rti;
            st_sel_dr: n = tms ? st_sel_ir : st_cap_dr;
            st_cap_dr: n = tms ? st_ex1_dr : st_sh_dr;
            st_sh_dr: n = tms ? st_ex1_dr : st_sh_dr;
            st_ex1_dr: n = tms ? st_upd_dr : st_pa_dr;
            st_pa_dr: n = tms ? st_ex2_dr : st_pa_dr;
            st_ex2_dr: n = tms ? st_upd_dr : st_sh_dr;
            st_upd_dr: n = tms ? st_sel_dr : st_rti;
            st_sel_ir: n = tms ? st_tlr : st_cap_ir;
            st_cap_ir: n = tms ? st_ex1_ir : st_sh_ir;
            st_sh_ir: n = tms ? st_ex1_ir : st_sh_ir;
            st_ex1_ir: n = tms ? st_upd_ir : st_pa_ir;
            st_pa_ir: n = tms ? st_ex2_ir : st_pa_ir;
            st_ex2_ir: n = tms ? st_upd_ir : st_sh_ir;
            st_upd_ir: n = tms ? st_sel_dr : st_rti;
        endcase
        return n;
    endfunction : tap_next

    // extest and sample put the boundary register on the path
    function automatic logic bsr_selected(input jtp_ir_type ir);
        return (ir == `JTP_IR_EXTEST) || (ir == `JTP_IR_SAMPLE);
    endfunction : bsr_selected

    jtp_core_state_type st;
    jtp_core_state_type next_st;
    logic [`JTP_PIN_COUNT-1:0] pin_raw;
    logic tck_rise;
    logic tck_fall;
    logic rise_take;
    logic fall_take;
    logic fall_needs_buf;
    logic buf_in_ready;
    logic push;

    assign pin_raw = {trst_n_in, tdi_in, tms_in, tck_in};

    // under extest or sample, a stalled receiver holds the falling edge of
    // update-dr, and any rising edge behind it, until the buffer has room
    assign fall_needs_buf = (st.tap == st_upd_dr) && bsr_selected(st.ir_cur);
    assign fall_take = ce_in && st.pend_fall && (!fall_needs_buf || buf_in_ready);
    assign rise_take = ce_in && st.pend_rise && !st.pend_fall;
    assign push = fall_take && fall_needs_buf;

    always_comb begin
        next_st = st;
        tck_rise = 1'b0;
        tck_fall = 1'b0;
        // three-stage pin synchronisers; a change counts once the
        // second and third stages agree
        for (int i = 0; i < `JTP_PIN_COUNT; i++) begin
            next_st.sync[i] = {st.sync[i][`JTP_SYNC_DEPTH-2:0], pin_raw[i]};
            if (st.sync[i][1] == st.sync[i][2]) begin
                next_st.lvl[i] = st.sync[i][2];
            end
        end
        tck_rise = !st.lvl[`JTP_PIN_TCK] && next_st.lvl[`JTP_PIN_TCK];
        tck_fall = st.lvl[`JTP_PIN_TCK] && !next_st.lvl[`JTP_PIN_TCK];

        // tck moves the controller only here, on a taken rising edge
        if (rise_take) begin
            next_st.pend_rise = 1'b0;
            next_st.tap = tap_next(st.tap, st.pend_tms);
            if (st.tap == st_tlr) begin
                next_st.ir_cur = `JTP_IR_RESET;
            end
            if (st.tap == st_cap_dr) begin
                if (st.ir_cur == `JTP_IR_SAMPLE) begin
                    next_st.bsr_shift = pins_in;
                end else if (!bsr_selected(st.ir_cur)) begin
                    next_st.bypass = 1'b0;
                end
            end
            // only the register on the path shifts; the other holds
            if (st.tap == st_sh_dr) begin
                if (bsr_selected(st.ir_cur)) begin
                    next_st.bsr_shift = {st.pend_tdi, st.bsr_shift[`JTP_BSR_LEN-1:1]};
                end else begin
                    next_st.bypass = st.pend_tdi;
                end
            end
            if (st.tap == st_cap_ir) begin
                next_st.ir_shift = `JTP_IR_CAPTURE;
            end
            if (st.tap == st_sh_ir) begin
                next_st.ir_shift = {st.pend_tdi, st.ir_shift[`JTP_IR_LEN-1:1]};
            end
        end

        if (fall_take) begin
            next_st.pend_fall = 1'b0;
            if (st.tap == st_sh_dr) begin
                next_st.tdo = bsr_selected(st.ir_cur) ? st.bsr_shift[0] : st.bypass;
                next_st.tdo_oe_n = 1'b0;
            end else if (st.tap == st_sh_ir) begin
                next_st.tdo = st.ir_shift[0];
                next_st.tdo_oe_n = 1'b0;
            end else begin
                next_st.tdo_oe_n = 1'b1;
            end
            if (fall_needs_buf) begin
                next_st.bsr_latch = st.bsr_shift;
            end
            if (st.tap == st_upd_ir) begin
                next_st.ir_cur = st.ir_shift;
            end
        end

        // a new edge is recorded after the old one is taken: set wins
        if (tck_rise) begin
            next_st.pend_rise = 1'b1;
            next_st.pend_tms = next_st.lvl[`JTP_PIN_TMS];
            next_st.pend_tdi = next_st.lvl[`JTP_PIN_TDI];
        end
        if (tck_fall) begin
            next_st.pend_fall = 1'b1;
        end

        // test reset pin overrides state, instruction, tdo enable and pending edges, independent of tck
        if (!st.lvl[`JTP_PIN_TRST]) begin
            next_st.tap = st_tlr;
            next_st.ir_cur = `JTP_IR_RESET;
            next_st.tdo_oe_n = 1'b1;
            next_st.pend_rise = 1'b0;
            next_st.pend_fall = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            st <= RESET_ST;
        end else if (ce_in) begin
            st <= next_st;
        end
    end

    jtp_buf2 #(
        .WIDTH(`JTP_BSR_LEN),
        .DEPTH(`JTP_BUF_DEPTH)
    ) u_upd_buf (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .ce_in(ce_in),
        .in_valid_in(push),
        .in_ready_out(buf_in_ready),
        .in_data_in(st.bsr_shift),
        .out_valid_out(upd_valid_out),
        .out_ready_in(upd_ready_in),
        .out_data_out(upd_word_out)
    );

    assign tdo_out = st.tdo;
    assign tdo_oe_n_out = st.tdo_oe_n;
    assign bsr_latch_out = st.bsr_latch;
    // enable cells are active low: a one leaves the pins undriven
    assign ad_oe_n_out = st.bsr_latch[`JTP_CELL_AD];
    assign lock_oe_n_out = st.bsr_latch[`JTP_CELL_LOCK];
    assign tap_state_out = st.tap;
    assign ir_out = st.ir_cur;

    // helper: consecutive taken rising edges with tms high
    logic [2:0] tms_high_cnt;
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            tms_high_cnt <= 3'h0;
        end else if (rise_take) begin
            if (!st.pend_tms) begin
                tms_high_cnt <= 3'h0;
            end else if (tms_high_cnt != 3'h7) begin
                tms_high_cnt <= tms_high_cnt + 3'h1;
            end
        end
    end

    logic [`JTP_BSR_LEN-2:0] bsr_upper;
    assign bsr_upper = st.bsr_shift[`JTP_BSR_LEN-1:1];

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rstn_in);

    a_capdr_exit: assert property (
        (rise_take && st.tap == st_cap_dr && st.lvl[`JTP_PIN_TRST])
        |=> (st.tap == ($past(st.pend_tms) ? st_ex1_dr : st_sh_dr)))
        else $error("capture-dr left to wrong state");

    a_shdr_shift: assert property (
        (rise_take && st.tap == st_sh_dr && bsr_selected(st.ir_cur))
        |=> (st.bsr_shift == {$past(st.pend_tdi), $past(bsr_upper)}))
        else $error("boundary path did not shift one place");

    a_shdr_stay: assert property (
        (rise_take && st.tap == st_sh_dr && !st.pend_tms
         && st.lvl[`JTP_PIN_TRST])
        |=> (st.tap == st_sh_dr))
        else $error("shift-dr left on tms low");

    a_pause_hold: assert property (
        (ce_in && st.tap == st_pa_dr) |=> $stable(st.bsr_shift))
        else $error("data register changed in pause-dr");

    a_latch_only_upd: assert property (
        !$stable(st.bsr_latch) |-> ($past(st.tap) == st_upd_dr))
        else $error("boundary latch changed outside update-dr");

    a_latch_copy: assert property (
        (push) |=> (st.bsr_latch == $past(st.bsr_shift)) && upd_valid_out)
        else $error("update-dr did not copy boundary word");

    a_ir_capture: assert property (
        (rise_take && st.tap == st_cap_ir)
        |=> (st.ir_shift == `JTP_IR_CAPTURE))
        else $error("capture-ir did not load fixed pattern");

    a_ir_hold: assert property (
        !$stable(st.ir_cur)
        |-> ($past(st.tap) == st_upd_ir) || ($past(st.tap) == st_tlr)
            || !$past(st.lvl[`JTP_PIN_TRST]))
        else $error("instruction changed outside update-ir");

    a_ir_update: assert property (
        (fall_take && st.tap == st_upd_ir && st.lvl[`JTP_PIN_TRST])
        |=> (st.ir_cur == $past(st.ir_shift)))
        else $error("update-ir did not make instruction current");

    a_selir_exit: assert property (
        (rise_take && st.tap == st_sel_ir && st.lvl[`JTP_PIN_TRST])
        |=> (st.tap == ($past(st.pend_tms) ? st_tlr : st_cap_ir)))
        else $error("select-ir left to wrong state");

    a_tms_reset: assert property (
        (tms_high_cnt >= 3'(`JTP_TLR_TMS_EDGES)) |-> (st.tap == st_tlr))
        else $error("five tms-high edges did not reset controller");

    a_trst_reset: assert property (
        (ce_in && !st.lvl[`JTP_PIN_TRST]) |=> (st.tap == st_tlr))
        else $error("test reset did not reach reset state");

    a_tdo_drive: assert property (
        (fall_take && st.tap != st_sh_dr && st.tap != st_sh_ir)
        |=> st.tdo_oe_n)
        else $error("tdo driven outside shift states");

    a_state_on_rise: assert property (
        (!$stable(st.tap))
        |-> $past(rise_take) || !$past(st.lvl[`JTP_PIN_TRST]))
        else $error("controller moved without a rising edge");

    a_ex1dr_exit: assert property (
        (rise_take && st.tap == st_ex1_dr && st.lvl[`JTP_PIN_TRST])
        |=> (st.tap == ($past(st.pend_tms) ? st_upd_dr : st_pa_dr)))
        else $error("exit1-dr left to wrong state");

    a_ex2dr_exit: assert property (
        (rise_take && st.tap == st_ex2_dr && st.lvl[`JTP_PIN_TRST])
        |=> (st.tap == ($past(st.pend_tms) ? st_upd_dr : st_sh_dr)))
        else $error("exit2-dr left to wrong state");

    a_upd_exit: assert property (
        (rise_take && (st.tap == st_upd_dr || st.tap == st_upd_ir) && st.lvl[`JTP_PIN_TRST])
        |=> (st.tap == ($past(st.pend_tms) ? st_sel_dr : st_rti)))
        else $error("update state left to wrong state");

    a_ir_shift: assert property (
        (rise_take && st.tap == st_sh_ir)
        |=> (st.ir_shift == {$past(st.pend_tdi), $past(st.ir_shift[`JTP_IR_LEN-1:1])}))
        else $error("instruction path did not shift one place");

    a_ex1ir_exit: assert property (
        (rise_take && st.tap == st_ex1_ir && st.lvl[`JTP_PIN_TRST])
        |=> (st.tap == ($past(st.pend_tms) ? st_upd_ir : st_pa_ir)))
        else $error("exit1-ir left to wrong state");

endmodule : jtp_scan_path
`default_nettype wire

// >>> verification/jtp_test_master.sv
/*
 jtp_test_master: external test master model that drives tck, tms and tdi
 and samples tdo. Assumes the bench calls step() once per tck period and
 that the bench core clock paces it; tck stands low between calls.
*/
`timescale 1ns/1ns
`default_nettype none

module jtp_test_master
    import jtp_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic tdo_in,
    input wire logic tdo_oe_n_in,
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out
);
    logic tdo_line;

    // released tdo floats up, as with a board pull-up
    assign tdo_line = tdo_oe_n_in ? 1'b1 : tdo_in;

    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b1;
    end

    // one 800 ns period; tms and tdi settle 4 core cycles before the rise
    // tdo is read late in the high phase, well after the last fall moved it
    task automatic step(input logic tms, input logic tdi, output logic tdo_seen);
        tms_out = tms;
        tdi_out = tdi;
        repeat (4) @(negedge core_clk_in);
        tck_out = 1'b1;
        repeat (4) @(negedge core_clk_in);
        tdo_seen = tdo_line;
        tck_out = 1'b0;
    endtask : step
endmodule : jtp_test_master

`default_nettype wire

// >>> verification/jtp_tap_scan_path_test.sv
/*
 jtp_tap_scan_path_test: self-checking bench of the scan path.
 Assumes jtp_pkg and jtp_test_master are compiled first; ce drops once.
*/
`timescale 1ns/1ns
`default_nettype none

module jtp_tap_scan_path_test;
    import jtp_pkg::*;
    localparam jtp_bsr_type pin_pat = 70'h2a_0ff0_1234_5678_9abc;
    localparam jtp_bsr_type scan_pat = 70'h15_c3a5_0f96_e1d2_4b78;
    logic core_clk, rstn, trst_n, tck, tms, tdi, tdo, tdo_oe_n;
    logic ad_oe_n, lock_oe_n, upd_ready, upd_valid, have_exp, tdo_q, ce;
    jtp_bsr_type pins, latch, upd_word;
    jtp_tap_state_type tap_state, exp_st;
    jtp_ir_type ir;
    int failures = 0;
    int cmp_count = 0;

    jtp_scan_path DUT (
        .core_clk_in(core_clk), .rstn_in(rstn), .ce_in(ce), .tck_in(tck), .tms_in(tms),
        .tdi_in(tdi), .trst_n_in(trst_n), .pins_in(pins), .tdo_out(tdo),
        .tdo_oe_n_out(tdo_oe_n), .bsr_latch_out(latch), .ad_oe_n_out(ad_oe_n),
        .lock_oe_n_out(lock_oe_n), .tap_state_out(tap_state), .ir_out(ir),
        .upd_ready_in(upd_ready), .upd_valid_out(upd_valid), .upd_word_out(upd_word)
    );

    jtp_test_master m (
        .core_clk_in(core_clk), .tdo_in(tdo), .tdo_oe_n_in(tdo_oe_n),
        .tck_out(tck), .tms_out(tms), .tdi_out(tdi)
    );

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic chk(input string what, input jtp_bsr_type seen, input jtp_bsr_type exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // state lags a step: it is read 6 cycles after the previous rise
    task automatic mv(input logic t, input logic d, input jtp_tap_state_type e);
        logic td;
        jtp_tap_state_type st;
        fork
            m.step(t, d, td);
            begin
                repeat (2) @(negedge core_clk);
                st = tap_state;
            end
        join
        if (have_exp) chk("state", 70'(st), 70'(exp_st));
        exp_st = e;
        have_exp = 1'b1;
        tdo_q = td;
    endtask : mv

    task automatic settle();
        repeat (6) @(negedge core_clk);
        chk("state", 70'(tap_state), 70'(exp_st));
        have_exp = 1'b0;
    endtask : settle

    task automatic check_reset();
        chk("reset state", 70'(tap_state), 70'(st_tlr));
        chk("reset ir", 70'(ir), 70'(4'h2));
        chk("reset oe", 70'(tdo_oe_n), 70'(1'b1));
        chk("reset latch", latch, '0);
        chk("reset valid", 70'(upd_valid), 70'(1'b0));
    endtask : check_reset

    // loads sample lsb first, with a pause in the middle of the shift
    task automatic ir_load();
        jtp_ir_type g;
        mv(1'b0, 1'b0, st_rti);
        mv(1'b1, 1'b0, st_sel_dr);
        mv(1'b1, 1'b0, st_sel_ir);
        mv(1'b0, 1'b0, st_cap_ir);
        mv(1'b0, 1'b0, st_sh_ir);
        mv(1'b0, 1'b1, st_sh_ir);
        g[0] = tdo_q;
        mv(1'b0, 1'b0, st_sh_ir);
        g[1] = tdo_q;
        mv(1'b1, 1'b0, st_ex1_ir);
        g[2] = tdo_q;
        mv(1'b0, 1'b0, st_pa_ir);
        mv(1'b0, 1'b0, st_pa_ir);
        chk("oe in pause", 70'(tdo_oe_n), 70'(1'b1));
        chk("ir in pause", 70'(ir), 70'(4'h2));
        mv(1'b1, 1'b0, st_ex2_ir);
        mv(1'b0, 1'b0, st_sh_ir);
        mv(1'b1, 1'b0, st_ex1_ir);
        g[3] = tdo_q;
        mv(1'b1, 1'b0, st_upd_ir);
        mv(1'b0, 1'b0, st_rti);
        settle();
        chk("ir capture", 70'(g), 70'(4'h1));
        chk("ir loaded", 70'(ir), 70'(4'h1));
    endtask : ir_load

    task automatic dr_sample();
        jtp_bsr_type got;
        mv(1'b1, 1'b0, st_sel_dr);
        mv(1'b0, 1'b0, st_cap_dr);
        mv(1'b0, 1'b0, st_sh_dr);
        for (int k = 0; k < 70; k++) begin
            if (k == 35) begin
                mv(1'b0, 1'b0, st_pa_dr);
                mv(1'b0, 1'b0, st_pa_dr);
                mv(1'b1, 1'b0, st_ex2_dr);
                mv(1'b0, 1'b0, st_sh_dr);
                chk("latch held", latch, '0);
            end
            mv(k == 34 || k == 69, scan_pat[k], (k == 34 || k == 69) ? st_ex1_dr : st_sh_dr);
            got[k] = tdo_q;
        end
        mv(1'b1, 1'b0, st_upd_dr);
        mv(1'b0, 1'b0, st_rti);
        settle();
        chk("captured pins", got, pin_pat);
        chk("latch", latch, scan_pat);
        chk("ad enable", 70'(ad_oe_n), 70'(scan_pat[54]));
        chk("lock enable", 70'(lock_oe_n), 70'(scan_pat[27]));
        chk("ir kept", 70'(ir), 70'(4'h1));
        chk("word valid", 70'(upd_valid), 70'(1'b1));
        chk("word", upd_word, scan_pat);
        upd_ready = 1'b1;
        @(negedge core_clk);
        upd_ready = 1'b0;
        chk("word gone", 70'(upd_valid), 70'(1'b0));
    endtask : dr_sample

    // third update finds the buffer full, so the controller must wait
    task automatic stall_fill();
        int pops;
        pops = 0;
        for (int n = 0; n < 3; n++) begin
            mv(1'b1, 1'b0, st_sel_dr);
            mv(1'b0, 1'b0, st_cap_dr);
            mv(1'b1, 1'b0, st_ex1_dr);
            mv(1'b1, 1'b0, st_upd_dr);
            mv(1'b0, 1'b0, st_rti);
        end
        repeat (4) @(negedge core_clk);
        chk("stalled", 70'(tap_state), 70'(st_upd_dr));
        chk("full", 70'(upd_valid), 70'(1'b1));
        upd_ready = 1'b1;
        for (int c = 0; c < 40; c++) begin
            if (upd_valid === 1'b1) begin
                chk("stalled word", upd_word, pin_pat);
                pops++;
            end
            @(negedge core_clk);
        end
        upd_ready = 1'b0;
        chk("pops", 70'(pops), 70'(3));
        settle();
    endtask : stall_fill

    task automatic ir_tlr();
        mv(1'b0, 1'b0, st_rti);
        mv(1'b1, 1'b0, st_sel_dr);
        mv(1'b1, 1'b0, st_sel_ir);
        mv(1'b0, 1'b0, st_cap_ir);
        mv(1'b1, 1'b0, st_ex1_ir);
        mv(1'b1, 1'b0, st_upd_ir);
        mv(1'b1, 1'b0, st_sel_dr);
        chk("ir unshifted", 70'(ir), 70'(4'h1));
        mv(1'b1, 1'b0, st_sel_ir);
        mv(1'b1, 1'b0, st_tlr);
        mv(1'b1, 1'b0, st_tlr);
        mv(1'b1, 1'b0, st_tlr);
        settle();
        chk("ir after tlr", 70'(ir), 70'(4'h2));
    endtask : ir_tlr

    task automatic trst_check();
        mv(1'b0, 1'b0, st_rti);
        mv(1'b1, 1'b0, st_sel_dr);
        mv(1'b1, 1'b0, st_sel_ir);
        mv(1'b0, 1'b0, st_cap_ir);
        mv(1'b0, 1'b0, st_sh_ir);
        settle();
        chk("oe shifting", 70'(tdo_oe_n), 70'(1'b0));
        ce = 1'b0;
        trst_n = 1'b0;
        repeat (8) @(negedge core_clk);
        chk("frozen state", 70'(tap_state), 70'(st_sh_ir));
        ce = 1'b1;
        repeat (8) @(negedge core_clk);
        chk("trst state", 70'(tap_state), 70'(st_tlr));
        chk("trst oe", 70'(tdo_oe_n), 70'(1'b1));
        chk("trst ir", 70'(ir), 70'(4'h2));
        trst_n = 1'b1;
        repeat (8) @(negedge core_clk);
    endtask : trst_check

    // reset instruction puts the one-bit bypass on the path; no update word
    task automatic dr_bypass();
        logic [1:0] b;
        mv(1'b0, 1'b0, st_rti);
        mv(1'b1, 1'b0, st_sel_dr);
        mv(1'b0, 1'b0, st_cap_dr);
        mv(1'b0, 1'b0, st_sh_dr);
        mv(1'b0, 1'b1, st_sh_dr);
        b[0] = tdo_q;
        mv(1'b1, 1'b0, st_ex1_dr);
        b[1] = tdo_q;
        mv(1'b1, 1'b0, st_upd_dr);
        mv(1'b0, 1'b0, st_rti);
        settle();
        chk("bypass bits", 70'(b), 70'(2'h2));
        chk("bypass latch", latch, pin_pat);
        chk("bypass no word", 70'(upd_valid), 70'(1'b0));
    endtask : dr_bypass

    task automatic give_verdict();
        $display("comparisons %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict

    // a hang counts as a mismatch
    initial begin
        #2000000;
        failures++;
        give_verdict();
    end

    initial begin
        rstn = 1'b0;
        trst_n = 1'b1;
        ce = 1'b1;
        upd_ready = 1'b0;
        pins = pin_pat;
        have_exp = 1'b0;
        tdo_q = 1'b0;
        exp_st = st_tlr;
        repeat (2) @(negedge core_clk);
        rstn = 1'b1;
        repeat (6) @(negedge core_clk);
        check_reset();
        ir_load();
        dr_sample();
        stall_fill();
        trst_check();
        ir_tlr();
        dr_bypass();
        give_verdict();
    end
endmodule : jtp_tap_scan_path_test

`default_nettype wire
